// ===== aasd_map.vh
// constants for the axis address strap decoder
// assumes strap samples arrive as 12-bit millivolt codes
// Summary of operation
// - each strap level is turned into a 3-bit code by eight rising bands, 0 to 0.53 V is 000 and 3.22 to 3.30 V is 111.
// - the axis address is 64 times the lower two bits of the upper code plus 8 times the middle code plus the lower code.
// - with all three straps open or grounded the address is 255 and the station alias reads zero.
// - the top bit of the upper code is dropped, so address bit 8 is always zero.
`ifndef AASD_MAP_VH
`define AASD_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// band upper edges in millivolts, a level equal to an edge stays in the lower band
`define AASD_EDGE1         12'd530
`define AASD_EDGE2         12'd1410
`define AASD_EDGE3         12'd2010
`define AASD_EDGE4         12'd2430
`define AASD_EDGE5         12'd2750
`define AASD_EDGE6         12'd3010
`define AASD_EDGE7         12'd3220

////////////////////////////////////////////////////////////////////////////////
// address packing
`define AASD_FALLBACK_ADDR 9'h0ff
`define AASD_HIGH_LSB      6
`define AASD_MID_LSB       3
`define AASD_LOW_LSB       0

////////////////////////////////////////////////////////////////////////////////
// register offsets
`define AASD_REG_AXIS      4'h0
`define AASD_REG_ALIAS     4'h1
`define AASD_REG_STATUS    4'h2

// reset values
`define AASD_ALIAS_RESET   16'h0000
`define AASD_ADDR_RESET    9'h000

////////////////////////////////////////////////////////////////////////////////
// settling time before the one-shot capture
`define AASD_CLK_MHZ       250
`define AASD_SETTLE_NS     1000
`define AASD_SETTLE_CYC    ((`AASD_SETTLE_NS * `AASD_CLK_MHZ + 999) / 1000)

`endif

// ===== aasd_decoder.v
// axis address strap decoder: band decode, packing, register port
// assumes strap samples come from an adc outside this clock domain
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "aasd_map.vh"

module aasd_decoder (
	// clock and reset
	input  wire        ref_clk,
	input  wire        rstn,
	// quantized strap levels, millivolts
	input  wire [11:0] strap_low,
	input  wire [11:0] strap_mid,
	input  wire [11:0] strap_high,
	// register port
	input  wire [3:0]  reg_addr,
	input  wire [15:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [15:0] reg_rdata,
	// decoded results
	output reg  [8:0]  axis_address,
	output reg  [15:0] station_alias,
	output reg         address_valid
);

////////////////////////////////////////////////////////////////////////////////
// band decode, used for all three straps
function [2:0] band_code;
	input [11:0] mv;
	begin
		if (mv <= `AASD_EDGE1) band_code = 3'h0;
		else if (mv <= `AASD_EDGE2) band_code = 3'h1;
		else if (mv <= `AASD_EDGE3) band_code = 3'h2;
		else if (mv <= `AASD_EDGE4) band_code = 3'h3;
		else if (mv <= `AASD_EDGE5) band_code = 3'h4;
		else if (mv <= `AASD_EDGE6) band_code = 3'h5;
		else if (mv <= `AASD_EDGE7) band_code = 3'h6;
		else band_code = 3'h7;
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// two-stage synchronisers; the bus is quasi-static straps
reg  [11:0] low_s1;
reg  [11:0] low_s2;
reg  [11:0] mid_s1;
reg  [11:0] mid_s2;
reg  [11:0] high_s1;
reg  [11:0] high_s2;

always @(posedge ref_clk) begin
	if (!rstn) begin
		low_s1  <= 12'h000;
		low_s2  <= 12'h000;
		mid_s1  <= 12'h000;
		mid_s2  <= 12'h000;
		high_s1 <= 12'h000;
		high_s2 <= 12'h000;
	end else begin
		low_s1  <= strap_low;
		low_s2  <= low_s1;
		mid_s1  <= strap_mid;
		mid_s2  <= mid_s1;
		high_s1 <= strap_high;
		high_s2 <= high_s1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// combinational decode of the synchronised levels
wire [2:0] code_low  = band_code(low_s2);
wire [2:0] code_mid  = band_code(mid_s2);
wire [2:0] code_high = band_code(high_s2);
wire       all_open  = (code_low == 3'h0) && (code_mid == 3'h0) && (code_high == 3'h0);

reg  [8:0] next_address;
always @* begin
	next_address = 9'h000;
	next_address[`AASD_HIGH_LSB +: 2] = code_high[1:0];
	next_address[`AASD_MID_LSB +: 3]  = code_mid;
	next_address[`AASD_LOW_LSB +: 3]  = code_low;
	if (all_open)
		next_address = `AASD_FALLBACK_ADDR;
end

////////////////////////////////////////////////////////////////////////////////
// one-shot capture; settle wait covers adc and synchroniser latency
localparam [9:0] SETTLE_CYC = `AASD_SETTLE_CYC;

reg  [9:0] settle_cnt;
reg        fallback;
reg  [2:0] cap_low;
reg  [2:0] cap_mid;
reg  [2:0] cap_high;
reg [15:0] alias_sw;

always @(posedge ref_clk) begin
	if (!rstn) begin
		settle_cnt    <= 10'h000;
		address_valid <= 1'b0;
		axis_address  <= `AASD_ADDR_RESET;
		fallback      <= 1'b0;
		cap_low       <= 3'h0;
		cap_mid       <= 3'h0;
		cap_high      <= 3'h0;
	end else if (!address_valid) begin
		if (settle_cnt == SETTLE_CYC - 10'h001) begin
			address_valid <= 1'b1;
			axis_address  <= next_address;
			fallback      <= all_open;
			cap_low       <= code_low;
			cap_mid       <= code_mid;
			cap_high      <= code_high;
		end else begin
			settle_cnt <= settle_cnt + 10'h001;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// alias: software writable, forced to zero in fallback
always @(posedge ref_clk) begin
	if (!rstn)
		alias_sw <= `AASD_ALIAS_RESET;
	else if (reg_wr && reg_addr == `AASD_REG_ALIAS)
		alias_sw <= reg_wdata;
end

always @(posedge ref_clk) begin
	if (!rstn)
		station_alias <= `AASD_ALIAS_RESET;
	else
		station_alias <= fallback ? 16'h0000 : alias_sw;
end

////////////////////////////////////////////////////////////////////////////////
// read port, data one cycle after the strobe; unmapped reads return zero
always @(posedge ref_clk) begin
	if (!rstn)
		reg_rdata <= 16'h0000;
	else if (reg_rd) begin
		case (reg_addr)
		`AASD_REG_AXIS:   reg_rdata <= {7'h00, axis_address};
		`AASD_REG_ALIAS:  reg_rdata <= fallback ? 16'h0000 : alias_sw;
		`AASD_REG_STATUS: reg_rdata <= {5'h00, cap_high, cap_mid, cap_low, fallback, address_valid};
		default:          reg_rdata <= 16'h0000;
		endcase
	end else
		reg_rdata <= 16'h0000;
end

endmodule // aasd_decoder
`default_nettype wire

// ===== aasd_monitor.sv
// assertions on the strap decoder ports
// assumes bind onto aasd_decoder, straps stable from reset release
`timescale 1ns/10ps
`default_nettype none
`include "aasd_map.vh"
module aasd_monitor (
	input wire logic        ref_clk,
	input wire logic        rstn,
	input wire logic        address_valid,
	input wire logic [11:0] strap_low,
	input wire logic [11:0] strap_mid,
	input wire logic [11:0] strap_high,
	input wire logic [8:0]  axis_address,
	input wire logic [15:0] station_alias
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	function automatic [2:0] cd(input [11:0] v);
		cd = (v > `AASD_EDGE1) + (v > `AASD_EDGE2) + (v > `AASD_EDGE3) + (v > `AASD_EDGE4)
			+ (v > `AASD_EDGE5) + (v > `AASD_EDGE6) + (v > `AASD_EDGE7);
	endfunction
	wire logic [8:0] pk = {1'b0, cd(strap_high[11:0]) & 3'h3, cd(strap_mid), cd(strap_low)};
	wire logic       fb = pk[5:0] == 6'h00 && cd(strap_high) == 3'h0;
	// capture edge decodes straps two edges older; valid is seen one edge after capture
	sequence s_calc; $rose(address_valid) && !$past(fb, 3); endsequence
	sequence s_fb; $rose(address_valid) && $past(fb, 3); endsequence
	a_code_pack: assert property (s_calc |-> axis_address == $past(pk, 3))
		else $error("packed address wrong");
	a_fallback_addr: assert property (s_fb |-> axis_address == 9'h0ff)
		else $error("fallback address wrong");
	a_alias_zero: assert property (s_fb |=> (station_alias == 16'h0000)[*4])
		else $error("alias not zero in fallback");
	a_bit8_zero: assert property (axis_address[8] == 1'b0)
		else $error("address bit 8 set");
	a_addr_hold: assert property (address_valid |=> address_valid && $stable(axis_address))
		else $error("address moved after capture");
endmodule // aasd_monitor
bind aasd_decoder aasd_monitor i_mon (.ref_clk, .rstn, .address_valid, .strap_low, .strap_mid,
	.strap_high, .axis_address, .station_alias);
`default_nettype wire

// ===== aasd_strap_board.sv
// board bias model: three strap levels in millivolts
// assumes the bench picks the bias; levels hold until changed
`timescale 1ns/10ps
`default_nettype none
module aasd_strap_board (
	input wire logic [35:0] bias,
	output logic     [11:0] strap_low,
	output logic     [11:0] strap_mid,
	output logic     [11:0] strap_high
);
	assign {strap_high, strap_mid, strap_low} = bias;
endmodule // aasd_strap_board
`default_nettype wire

// ===== aasd_decoder_tb.sv
// self-checking bench for the strap decoder
// assumes design, header and checker in the same folder
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module aasd_decoder_tb;
	logic ref_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, address_valid;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, station_alias;
	logic [35:0] bias = 36'h0;
	logic [11:0] strap_low, strap_mid, strap_high;
	logic [8:0] axis_address;
	int num_errors = 0, samples_checked = 0;
	// high, mid, low level, expected address and status; entry 2 has all three straps in the lowest band
	logic [60:0] tests [5] = '{{12'd3221, 12'd531, 12'd530, 9'h0c8, 16'h0721},
		{12'd2011, 12'd2010, 12'd3300, 9'h0d7, 16'h035d},
		{12'd530, 12'd0, 12'd0, 9'h0ff, 16'h0003},
		{12'd3010, 12'd2750, 12'd2430, 9'h063, 16'h058d},
		{12'd3011, 12'd2751, 12'd2431, 9'h0ac, 16'h06b1}};
	aasd_strap_board i_brd (.bias, .strap_low, .strap_mid, .strap_high);
	aasd_decoder i_dut (.ref_clk, .rstn, .strap_low, .strap_mid, .strap_high, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .axis_address, .station_alias, .address_valid);
	initial forever #2 ref_clk = ~ref_clk;
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge ref_clk) begin reg_rd <= 1'b1; reg_addr <= a; end
		@(posedge ref_clk) reg_rd <= 1'b0;
		#1 `CHK(reg_rdata, e)
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
		@(posedge ref_clk) reg_wr <= 1'b0;
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 5; i++) begin
			@(posedge ref_clk) begin rstn <= 1'b0; bias <= tests[i][60:25]; end
			repeat (5) @(posedge ref_clk);
			rstn <= 1'b1;
			for (int k = 0; k < 300 && address_valid !== 1'b1; k++) @(posedge ref_clk);
			#1 `CHK(axis_address, tests[i][24:16])
			wr(4'h0, 16'h01ff);
			rd(4'h0, {7'h00, tests[i][24:16]});
			rd(4'h2, tests[i][15:0]);
			wr(4'h1, 16'h5a5a);
			rd(4'h1, i == 2 ? 16'h0000 : 16'h5a5a);
			`CHK(station_alias, i == 2 ? 16'h0000 : 16'h5a5a)
			@(posedge ref_clk) bias <= ~bias;
			repeat (8) @(posedge ref_clk);
			#1 `CHK(axis_address, tests[i][24:16])
			$display("test %0d done", i);
		end
		rd(4'hf, 16'h0000);
		print_verdict;
	end
	initial begin
		#40000;
		num_errors++;
		print_verdict;
	end
endmodule // aasd_decoder_tb
`default_nettype wire
